/* core/desc_framer.sv */
// Upstream channel descriptor framer with APB registers
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module desc_framer #(
  parameter int PERIOD_CYCLES = desc_pkg::PERIOD_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire desc_pkg::apb_req_s    apb_req,
  output      desc_pkg::apb_rsp_s    apb_rsp,
  output      desc_pkg::frame_beat_s beat,
  output      logic                  beat_valid,
  input  wire logic                  beat_ready
);

  // ********************
  // Functions
  // ********************

  // Field code: 0 none, 1 ctrl, 2 period, 3 cfg, 4 mask, 5 stat
  function automatic logic [2:0] addr_field(input logic [11:0] a);
    logic [3:0] blk;
    blk = a[7:4];
    if (a == desc_pkg::OFS_CTRL) return 3'h1;
    if (a == desc_pkg::OFS_PERIOD) return 3'h2;
    if (a[11:8] != 4'h0 || blk == 4'h0 || blk > 4'(desc_pkg::NUM_CH)) return 3'h0;
    if ({8'h00, a[3:0]} == desc_pkg::OFS_CH_CFG) return 3'h3;
    if ({8'h00, a[3:0]} == desc_pkg::OFS_CH_MASK) return 3'h4;
    if ({8'h00, a[3:0]} == desc_pkg::OFS_CH_STAT) return 3'h5;
    return 3'h0;
  endfunction : addr_field

  function automatic logic [1:0] addr_ch(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - desc_pkg::OFS_CH_BASE;
    return rel[5:4];
  endfunction : addr_ch

  // Message type for a channel type; second selects the 35 of a pair
  function automatic logic [7:0] msg_of(input logic [2:0] t, input logic pair,
                                        input logic second);
    case (t)
      3'h5:    return desc_pkg::MT_T5;
      3'h4:    return (pair && !second) ? desc_pkg::MT_T3 : desc_pkg::MT_T4;
      3'h3:    return desc_pkg::MT_T3;
      default: return desc_pkg::MT_LEGACY;
    endcase
  endfunction : msg_of

  function automatic logic [7:0] ver_of(input logic [7:0] m);
    case (m)
      desc_pkg::MT_T5: return desc_pkg::VER_T5;
      desc_pkg::MT_T4: return desc_pkg::VER_T4;
      desc_pkg::MT_T3: return desc_pkg::VER_T3;
      default:         return desc_pkg::VER_LEGACY;
    endcase
  endfunction : ver_of

  // Burst descriptor TLV type for one usage code
  function automatic logic [7:0] bd_of(input logic [7:0] m, input logic [3:0] interval_usage_code);
    if (m == desc_pkg::MT_T5) return desc_pkg::BD_OFDMA;
    if (m != desc_pkg::MT_LEGACY) return desc_pkg::BD_ADV;
    if (desc_pkg::IUC_LEGACY[interval_usage_code]) return desc_pkg::BD_LEGACY;
    return desc_pkg::BD_ADV;
  endfunction : bd_of

  // Usage codes actually sent, corrected from the software mask
  function automatic logic [15:0] eff_mask(input logic [7:0] m, input logic [2:0] t,
                                           input logic [15:0] sw);
    logic [15:0] e;
    e = sw;
    case (m)
      desc_pkg::MT_LEGACY: begin
        if (t == 3'h1) e = e & ~desc_pkg::IUC_ADV_DATA;
        else if ((e & desc_pkg::IUC_ADV_DATA) == 16'h0000) begin
          e = e | desc_pkg::IUC_ADV_MIN;
        end
      end
      desc_pkg::MT_T3: begin
        e = e | desc_pkg::IUC_T29_REQ;
        if (t == 3'h3) e = e & ~desc_pkg::IUC_T3_NONE;
      end
      desc_pkg::MT_T4: e = e | desc_pkg::IUC_T35_REQ;
      default: e = sw;
    endcase
    if (m == desc_pkg::MT_T3 && t == 3'h4) e = e & ~desc_pkg::IUC_T3_NONE;
    return e;
  endfunction : eff_mask

  function automatic logic [3:0] low_index(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) r = 4'(i);
    end
    return r;
  endfunction : low_index

  function automatic logic usable(input logic [31:0] c);
    logic [2:0] t;
    t = c[desc_pkg::CFG_TYPE_LSB +: 3];
    return c[desc_pkg::CFG_EN] && t >= 3'h1 && t <= 3'h5;
  endfunction : usable

  // ********************
  // Registers
  // ********************
  logic [31:0]           ctrl_reg;
  logic [31:0]           period_reg;
  logic [31:0]           cfg_reg  [desc_pkg::NUM_CH];
  logic [15:0]           mask_reg [desc_pkg::NUM_CH];
  logic [7:0]            ccc_reg  [desc_pkg::NUM_CH];
  logic [31:0]           prdata_reg;
  logic                  pslverr_reg;
  logic [2:0]            fld;
  logic [1:0]            wch;
  logic                  wr_en;
  logic                  rd_setup;

  assign fld      = addr_field(apb_req.paddr);
  assign wch      = addr_ch(apb_req.paddr);
  assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable;

  // Zero wait state slave
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = prdata_reg;
  assign apb_rsp.pslverr = pslverr_reg;

  // Global control writes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg   <= desc_pkg::CTRL_RESET;
      period_reg <= 32'(PERIOD_CYCLES);
    end else if (wr_en && fld == 3'h1) begin
      ctrl_reg <= apb_req.pwdata;
    end else if (wr_en && fld == 3'h2) begin
      period_reg <= apb_req.pwdata;
    end
  end

  // Per channel config, mask and change count
  for (genvar g = 0; g < desc_pkg::NUM_CH; g++) begin : g_ch
    logic hit;
    logic changed;
    assign hit     = wr_en && wch == 2'(g);
    assign changed = (hit && fld == 3'h3 && apb_req.pwdata != cfg_reg[g]) ||
                     (hit && fld == 3'h4 && apb_req.pwdata[15:0] != mask_reg[g]);

    always_ff @(posedge clock) begin
      if (!reset_n) begin
        cfg_reg[g]  <= desc_pkg::CFG_RESET;
        mask_reg[g] <= desc_pkg::MASK_RESET;
      end else if (hit && fld == 3'h3) begin
        cfg_reg[g] <= apb_req.pwdata;
      end else if (hit && fld == 3'h4) begin
        mask_reg[g] <= apb_req.pwdata[15:0];
      end
    end

    // One count per channel serves both paired messages
    always_ff @(posedge clock) begin
      if (!reset_n) ccc_reg[g] <= 8'h00;
      else if (changed) ccc_reg[g] <= ccc_reg[g] + 8'h01;
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (rd_setup) begin
      pslverr_reg <= (fld == 3'h0);
      case (fld)
        3'h1: prdata_reg <= ctrl_reg;
        3'h2: prdata_reg <= period_reg;
        3'h3: prdata_reg <= cfg_reg[wch];
        3'h4: prdata_reg <= {16'h0000, mask_reg[wch]};
        3'h5: begin
          prdata_reg <= {22'h000000,
            !usable(cfg_reg[wch]) && cfg_reg[wch][desc_pkg::CFG_EN],
            eff_mask(msg_of(cfg_reg[wch][2:0], cfg_reg[wch][desc_pkg::CFG_PAIR], 1'b0),
                     cfg_reg[wch][2:0], mask_reg[wch]) != mask_reg[wch],
            ccc_reg[wch]};
        end
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ********************
  // Period timer
  // ********************
  logic [31:0]           tick_cnt_reg;
  logic                  tick;
  logic                  pending_reg;
  logic                  take;

  assign tick = ctrl_reg[0] && tick_cnt_reg == 32'h0000_0000;

  // Counts down the round period while running
  always_ff @(posedge clock) begin
    if (!reset_n) tick_cnt_reg <= 32'h0000_0000;
    else if (!ctrl_reg[0] || tick) tick_cnt_reg <= period_reg - 32'h0000_0001;
    else tick_cnt_reg <= tick_cnt_reg - 32'h0000_0001;
  end

  // A tick arriving as the round starts is kept
  always_ff @(posedge clock) begin
    if (!reset_n) pending_reg <= 1'b0;
    else pending_reg <= tick || (pending_reg && !take);
  end

  // ********************
  // Sequencer
  // ********************
  desc_pkg::seq_state_e  state_reg;
  desc_pkg::frame_beat_s beat_reg;
  logic                  beat_valid_reg;
  logic [1:0]            ch_reg;
  logic                  second_reg;
  logic [2:0]            idx_reg;
  logic [1:0]            sub_reg;
  logic [15:0]           rem_reg;
  logic [7:0]            msg_reg;
  logic [7:0]            ccc_snap_reg;
  logic [31:0]           cur_cfg;
  logic                  paired;
  logic [2:0]            hdr_last;
  logic [15:0]           low_bit;
  logic [3:0]            interval_usage_code;
  logic                  out_load;
  logic                  emit;
  desc_pkg::frame_beat_s cur;

  assign cur_cfg  = cfg_reg[ch_reg];
  assign paired   = cur_cfg[desc_pkg::CFG_PAIR] && cur_cfg[2:0] == 3'h4;
  assign hdr_last = paired ? 3'h6 : 3'h3;
  assign low_bit  = rem_reg & (~rem_reg + 16'h0001);
  assign interval_usage_code      = low_index(rem_reg);
  assign out_load = !beat_valid_reg || beat_ready;
  assign emit     = out_load && (state_reg == desc_pkg::S_HDR ||
                                 state_reg == desc_pkg::S_BURST);
  assign take     = state_reg == desc_pkg::S_IDLE && pending_reg;

  // Next byte of the current message
  always_comb begin
    cur               = '0;
    cur.ds_mask       = cur_cfg[desc_pkg::CFG_DS_LSB +: 8];
    cur.first         = state_reg == desc_pkg::S_HDR && idx_reg == 3'h0;
    cur.preamble_qpsk = bd_of(msg_reg, interval_usage_code) == desc_pkg::BD_ADV;
    if (state_reg == desc_pkg::S_HDR) begin
      cur.last = idx_reg == hdr_last && rem_reg == 16'h0000;
      case (idx_reg)
        3'h0: cur.data = msg_reg;
        3'h1: cur.data = ver_of(msg_reg);
        3'h2: cur.data = ccc_snap_reg;
        3'h3: cur.data = cur_cfg[desc_pkg::CFG_UPSTREAM_CHANNEL_ID_LSB +: 8];
        3'h4: cur.data = second_reg ? desc_pkg::TLV_CODES : desc_pkg::TLV_BITMAP;
        3'h5: cur.data = desc_pkg::TLV_LEN;
        default: begin
          cur.data = second_reg ? {7'h00, cur_cfg[desc_pkg::CFG_TLV20]}
                                : desc_pkg::BITMAP_VAL;
        end
      endcase
    end else begin
      cur.last = sub_reg == 2'h2 && (rem_reg & ~low_bit) == 16'h0000;
      case (sub_reg)
        2'h0:    cur.data = bd_of(msg_reg, interval_usage_code);
        2'h1:    cur.data = desc_pkg::TLV_LEN;
        default: cur.data = {4'h0, interval_usage_code};
      endcase
    end
  end

  // Message walk: usable channels in order, one message each, pairs back to back
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg    <= desc_pkg::S_IDLE;
      ch_reg       <= 2'h0;
      second_reg   <= 1'b0;
      idx_reg      <= 3'h0;
      sub_reg      <= 2'h0;
      rem_reg      <= 16'h0000;
      msg_reg      <= 8'h00;
      ccc_snap_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        desc_pkg::S_IDLE: begin
          if (take) begin
            ch_reg     <= 2'h0;
            second_reg <= 1'b0;
            state_reg  <= desc_pkg::S_PICK;
          end
        end
        desc_pkg::S_PICK: begin
          msg_reg <= msg_of(cur_cfg[2:0], paired, second_reg);
          rem_reg <= eff_mask(msg_of(cur_cfg[2:0], paired, second_reg),
                              cur_cfg[2:0], mask_reg[ch_reg]);
          idx_reg <= 3'h0;
          sub_reg <= 2'h0;
          if (!second_reg) ccc_snap_reg <= ccc_reg[ch_reg];
          state_reg <= usable(cur_cfg) ? desc_pkg::S_HDR : desc_pkg::S_NEXT;
        end
        desc_pkg::S_HDR: begin
          if (emit) begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == hdr_last) begin
              state_reg <= (rem_reg == 16'h0000) ? desc_pkg::S_NEXT : desc_pkg::S_BURST;
            end
          end
        end
        desc_pkg::S_BURST: begin
          if (emit) begin
            sub_reg <= (sub_reg == 2'h2) ? 2'h0 : sub_reg + 2'h1;
            if (sub_reg == 2'h2) begin
              rem_reg <= rem_reg & ~low_bit;
              if ((rem_reg & ~low_bit) == 16'h0000) state_reg <= desc_pkg::S_NEXT;
            end
          end
        end
        desc_pkg::S_NEXT: begin
          if (paired && usable(cur_cfg) && !second_reg) begin
            second_reg <= 1'b1;
            state_reg  <= desc_pkg::S_PICK;
          end else begin
            second_reg <= 1'b0;
            ch_reg     <= ch_reg + 2'h1;
            state_reg  <= (ch_reg == 2'(desc_pkg::NUM_CH - 1)) ? desc_pkg::S_IDLE
                                                               : desc_pkg::S_PICK;
          end
        end
        default: state_reg <= desc_pkg::S_IDLE;
      endcase
    end
  end

  // Output register, stalls under back-pressure
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      beat_reg       <= '0;
      beat_valid_reg <= 1'b0;
    end else if (out_load) begin
      beat_valid_reg <= emit;
      if (emit) beat_reg <= cur;
    end
  end

  assign beat       = beat_reg;
  assign beat_valid = beat_valid_reg;

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_type5;
    emit && cur.first && cur_cfg[2:0] == 3'h5 |=> beat.data == 8'h33 && beat.first;
  endproperty
  a_type5: assert property (p_type5) else $error("type 5 message code wrong");

  property p_type4;
    emit && cur.first && cur_cfg[2:0] == 3'h4 && (!paired || second_reg)
      |=> beat.data == 8'h23;
  endproperty
  a_type4: assert property (p_type4) else $error("type 4 message code wrong");

  property p_type3;
    emit && cur.first && cur_cfg[2:0] == 3'h3 |=> beat.data == 8'h1D ##1 1'b1;
  endproperty
  a_type3: assert property (p_type3) else $error("type 3 message code wrong");

  property p_ver1;
    emit && state_reg == desc_pkg::S_HDR && idx_reg == 3'h1 && msg_reg == 8'h02
      |=> beat.data == 8'h01;
  endproperty
  a_ver1: assert property (p_ver1) else $error("legacy version wrong");

  property p_legacy_bd;
    emit && state_reg == desc_pkg::S_BURST && sub_reg == 2'h0 && msg_reg == 8'h02 &&
      interval_usage_code >= 4'h1 && interval_usage_code <= 4'h6 |=> beat.data == 8'h04;
  endproperty
  a_legacy_bd: assert property (p_legacy_bd) else $error("legacy code as type 5");

  property p_adv_bd;
    emit && state_reg == desc_pkg::S_BURST && sub_reg == 2'h0 &&
      (msg_reg == 8'h1D || msg_reg == 8'h23) |=> beat.data == 8'h05 && beat.preamble_qpsk;
  endproperty
  a_adv_bd: assert property (p_adv_bd) else $error("29/35 not type 5");

  property p_ofdma_bd;
    emit && state_reg == desc_pkg::S_BURST && sub_reg == 2'h0 && msg_reg == 8'h33
      |=> beat.data == 8'h17;
  endproperty
  a_ofdma_bd: assert property (p_ofdma_bd) else $error("51 not type 23");

  property p_t3_omit;
    state_reg == desc_pkg::S_BURST && msg_reg == 8'h1D |-> rem_reg[6:5] == 2'b00;
  endproperty
  a_t3_omit: assert property (p_t3_omit) else $error("codes 5/6 in 29");

  property p_ccc;
    wr_en && fld == 3'h3 && wch == 2'h0 && apb_req.pwdata != cfg_reg[0]
      |=> ccc_reg[0] == $past(ccc_reg[0]) + 8'h01;
  endproperty
  a_ccc: assert property (p_ccc) else $error("change count not stepped");

endmodule : desc_framer

/* core/desc_pkg.sv */
// Constants, types and register map for the upstream channel descriptor framer
package desc_pkg;

  // ********************
  // Register map
  // ********************
  localparam logic [11:0] OFS_CTRL     = 12'h000;  // [0] run
  localparam logic [11:0] OFS_PERIOD   = 12'h004;  // Cycles between descriptor rounds
  localparam logic [11:0] OFS_CH_BASE  = 12'h010;  // First channel block
  localparam logic [11:0] OFS_CH_CFG   = 12'h000;  // Within a channel block
  localparam logic [11:0] OFS_CH_MASK  = 12'h004;
  localparam logic [11:0] OFS_CH_STAT  = 12'h008;
  localparam int          NUM_CH       = 4;

  // Channel config fields
  localparam int CFG_TYPE_LSB = 0;   // Upstream channel type, 3 bits
  localparam int CFG_EN       = 3;   // Channel open for use
  localparam int CFG_PAIR     = 4;   // Type 4 channel also described by type 29
  localparam int CFG_TLV20    = 5;   // Value carried in type 20 TLV
  localparam int CFG_UPSTREAM_CHANNEL_ID_LSB = 8;   // upstream_channel_id, 8 bits
  localparam int CFG_DS_LSB   = 16;  // Downstreams carrying the map, 8 bits
  localparam int STAT_ADJ     = 8;   // Mask was corrected
  localparam int STAT_BADTYPE = 9;   // Channel type not usable

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [15:0] MASK_RESET  = 16'h0000;

  // ********************
  // Message coding
  // ********************
  localparam logic [7:0] MT_LEGACY = 8'h02;
  localparam logic [7:0] VER_LEGACY = 8'h01;
  localparam logic [7:0] MT_T3     = 8'h1D;
  localparam logic [7:0] VER_T3    = 8'h03;
  localparam logic [7:0] MT_T4     = 8'h23;
  localparam logic [7:0] VER_T4    = 8'h04;
  localparam logic [7:0] MT_T5     = 8'h33;
  localparam logic [7:0] VER_T5    = 8'h05;
  localparam logic [7:0] BD_LEGACY = 8'h04;
  localparam logic [7:0] BD_ADV    = 8'h05;
  localparam logic [7:0] BD_OFDMA  = 8'h17;
  localparam logic [7:0] TLV_BITMAP = 8'h16;
  localparam logic [7:0] TLV_CODES  = 8'h14;
  localparam logic [7:0] TLV_LEN    = 8'h01;
  localparam logic [7:0] BITMAP_VAL = 8'h01;

  // Interval usage code sets
  localparam logic [15:0] IUC_LEGACY   = 16'h007E;  // Codes 1..6
  localparam logic [15:0] IUC_ADV_DATA = 16'h0E00;  // Codes 9..11
  localparam logic [15:0] IUC_ADV_MIN  = 16'h0200;  // Code 9
  localparam logic [15:0] IUC_T3_NONE  = 16'h0060;  // Codes 5, 6
  localparam logic [15:0] IUC_T35_REQ  = 16'h0660;  // Codes 5, 6, 9, 10
  localparam logic [15:0] IUC_T29_REQ  = 16'h020A;  // Request 1, ranging 3, data 9

  // ********************
  // Timing
  // ********************
  localparam int CLK_MHZ    = 100;
  localparam int PERIOD_US  = 1000;
  localparam int PERIOD_CYC = PERIOD_US * CLK_MHZ;

  // ********************
  // Types
  // ********************
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_PICK  = 3'b001,
    S_HDR   = 3'b010,
    S_BURST = 3'b011,
    S_NEXT  = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
    logic       preamble_qpsk;
    logic [7:0] ds_mask;
  } frame_beat_s;

endpackage : desc_pkg

/* testbench/beat_sink.sv */
// Downstream sink model that takes framed descriptor beats
`timescale 1ns/1ps
module beat_sink (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire desc_pkg::frame_beat_s beat,
  input  wire logic                  beat_valid,
  input  wire logic                  slow,
  output      logic                  beat_ready
);
  logic [17:0] got[$];
  logic        phase_reg;
  // Ready drops every other cycle when the bench asks for a slow sink
  always_ff @(posedge clock) begin
    if (!reset_n) phase_reg <= 1'b0;
    else phase_reg <= ~phase_reg;
  end
  assign beat_ready = slow ? phase_reg : 1'b1;
  logic [2:0]  pos_reg;
  logic [7:0]  mt_reg;
  logic [7:0]  tlv_reg;
  logic [7:0]  upstream_channel_id_reg;
  logic [7:0]  best_reg;
  logic        hint_reg;
  logic [2:0]  pos;
  logic        take;
  assign take = reset_n && beat_valid && beat_ready;
  assign pos  = beat.first ? 3'h0 : pos_reg;
  // Byte position within the message, saturating past the header TLV
  always_ff @(posedge clock) begin
    if (!reset_n) pos_reg <= 3'h0;
    else if (take && pos != 3'h7) pos_reg <= pos + 3'h1;
  end
  // Modem view: highest message type per channel id and the type bitmap hint
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mt_reg   <= 8'h00;
      tlv_reg  <= 8'h00;
      upstream_channel_id_reg <= 8'h00;
      best_reg <= 8'h00;
      hint_reg <= 1'b0;
    end else if (take) begin
      if (pos == 3'h0) mt_reg <= beat.data;
      if (pos == 3'h4) tlv_reg <= beat.data;
      if (pos == 3'h3 && beat.data != upstream_channel_id_reg) begin
        upstream_channel_id_reg <= beat.data;
        best_reg <= mt_reg;
        hint_reg <= 1'b0;
      end else if (pos == 3'h3 && mt_reg > best_reg) begin
        best_reg <= mt_reg;
      end
      if (pos == 3'h6 && tlv_reg == 8'h16) hint_reg <= beat.data[0];
    end
  end
  // Record each taken byte with its framing flags and downstream mask
  always_ff @(posedge clock) begin
    if (reset_n && beat_valid && beat_ready)
      got.push_back({beat.first, beat.last, beat.ds_mask, beat.data});
  end
endmodule : beat_sink

/* testbench/tb_top.sv */
// Self-checking bench for the descriptor framer
`timescale 1ns/1ps
module tb_top;
  localparam int PER = 40;
  logic                  clock = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  slow = 1'b0;
  desc_pkg::apb_req_s    apb_req = '0;
  desc_pkg::apb_rsp_s    apb_rsp;
  desc_pkg::frame_beat_s beat;
  logic                  beat_valid;
  logic                  beat_ready;
  int                    num_errors = 0;
  int                    n_tests = 0;
  int                    cycles = 0;
  logic [7:0]            cc = 8'h00;
  logic [31:0]           cfg_sh = '0;
  logic [31:0]           mask_sh = '0;
  logic [31:0]           rd;
  logic                  err;
  logic [7:0]            exp_q[$];

  desc_framer #(.PERIOD_CYCLES(PER)) desc_framer_i (.clock(clock), .reset_n(reset_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .beat(beat), .beat_valid(beat_valid),
    .beat_ready(beat_ready));
  beat_sink beat_sink_i (.clock(clock), .reset_n(reset_n), .beat(beat),
    .beat_valid(beat_valid), .slow(slow), .beat_ready(beat_ready));

  // ********************
  // Clock and hang guard
  // ********************
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      close_out();
    end
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer, held until pready is seen with the access phase
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  // Channel 0 setup; the change count steps on every write that alters a value
  task automatic wr_ch(input logic [31:0] c, input logic [31:0] m);
    apb(1'b1, 12'h010, c);
    if (c !== cfg_sh) cc++;
    cfg_sh = c;
    apb(1'b1, 12'h014, m);
    if (m[15:0] !== mask_sh[15:0]) cc++;
    mask_sh = m;
    apb(1'b0, 12'h018, '0);
    chk("change_count", {24'h0, cc}, {24'h0, rd[7:0]});
  endtask : wr_ch

  // Run rounds until n bytes arrive, then compare them with exp_q
  task automatic run_round(input int n, input logic full);
    int w;
    beat_sink_i.got.delete();
    apb(1'b1, 12'h000, 32'h1);
    for (w = 0; w < 900 && beat_sink_i.got.size() < n; w++) @(posedge clock);
    apb(1'b1, 12'h000, 32'h0);
    repeat (80) @(posedge clock);
    chk("byte_count", 32'h1, {31'h0, beat_sink_i.got.size() >= n});
    for (w = 0; w < n && w < beat_sink_i.got.size(); w++) begin
      chk("data", {24'h0, exp_q[w]}, {24'h0, beat_sink_i.got[w][7:0]});
      chk("ds_mask", {24'h0, cfg_sh[23:16]}, {24'h0, beat_sink_i.got[w][15:8]});
    end
    chk("first", 32'h1, {31'h0, beat_sink_i.got[0][17]});
    if (full) chk("last", 32'h1, {31'h0, beat_sink_i.got[n-1][16]});
  endtask : run_round

  // ********************
  // Scenarios
  // ********************
  task automatic sc_regs();
    apb(1'b0, 12'h004, '0);
    chk("period", PER, rd);
    apb(1'b0, 12'h000, '0);
    chk("ctrl", 32'h0, rd);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, 12'h018, 32'h0000_00FF);
    apb(1'b0, 12'h018, '0);
    chk("stat_ro", {24'h0, cc}, {24'h0, rd[7:0]});
    // Channel 1 enabled with an unusable type: flagged, counted, never sent
    apb(1'b1, 12'h020, 32'h0000_0008);
    apb(1'b0, 12'h028, '0);
    chk("bad_type", 32'h0000_0101, {23'h0, rd[9], rd[7:0]});
  endtask : sc_regs

  task automatic sc_types();
    logic [7:0] mt[1:5];
    logic [7:0] ver[1:5];
    int t;
    mt = '{8'h02, 8'h02, 8'h1D, 8'h23, 8'h33};
    ver = '{8'h01, 8'h01, 8'h03, 8'h04, 8'h05};
    for (t = 1; t <= 5; t++) begin
      wr_ch({16'h0001, 8'(t), 8'(8 + t)}, 32'h0000_0002);
      exp_q = '{mt[t], ver[t], cc, 8'(t)};
      run_round(4, 1'b0);
    end
  endtask : sc_types

  task automatic sc_type5();
    slow <= 1'b1;
    wr_ch(32'h0002_070D, 32'h0000_0002);
    exp_q = '{8'h33, 8'h05, cc, 8'h07, 8'h17, 8'h01, 8'h01};
    run_round(7, 1'b1);
  endtask : sc_type5

  task automatic sc_mixed();
    wr_ch(32'h0001_090A, 32'h0000_0006);
    exp_q = '{8'h02, 8'h01, cc, 8'h09, 8'h04, 8'h01, 8'h01, 8'h04, 8'h01, 8'h02,
              8'h05, 8'h01, 8'h09};
    run_round(13, 1'b1);
    apb(1'b0, 12'h018, '0);
    chk("mask_fixed", 32'h1, {31'h0, rd[8]});
  endtask : sc_mixed

  task automatic sc_paired();
    wr_ch(32'h0005_213C, 32'h0000_0060);
    exp_q = '{8'h1D, 8'h03, cc, 8'h21, 8'h16, 8'h01, 8'h01, 8'h05, 8'h01, 8'h01,
              8'h05, 8'h01, 8'h03, 8'h05, 8'h01, 8'h09,
              8'h23, 8'h04, cc, 8'h21, 8'h14, 8'h01, 8'h01, 8'h05, 8'h01, 8'h05,
              8'h05, 8'h01, 8'h06, 8'h05, 8'h01, 8'h09, 8'h05, 8'h01, 8'h0A};
    run_round(35, 1'b1);
    chk("second_first", 32'h1, {31'h0, beat_sink_i.got[16][17]});
    chk("modem_pick", 32'h23, {24'h0, beat_sink_i.best_reg});
    chk("bitmap_hint", 32'h1, {31'h0, beat_sink_i.hint_reg});
    slow <= 1'b0;
  endtask : sc_paired

  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    sc_regs();
    sc_types();
    sc_type5();
    sc_mixed();
    sc_paired();
    close_out();
  end
endmodule : tb_top
